/* rtl/dma_sw_port.sv */
// APB software port that configures the arbiter and reports its events
`timescale 1ns/1ps
module dma_sw_port (
   input wire logic pclk, // 200 MHz clock
   input wire logic presetn, // Asynchronous reset, active low
   dma_req_if.sw link, // Toward the arbiter
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [dma_arb_pkg::NUM_CH-1:0] count_zero, // Transfer count is zero
   output logic irq // Level interrupt
);
   localparam int NCH = dma_arb_pkg::NUM_CH;

   logic [7:0] mode_sw_reg;
   logic [7:0] mode_out_reg;
   logic [7:0] mode_out_next;
   logic [7:0] shadow_reg [NCH];
   logic [4:0] guard_reg [NCH];
   logic pend_reg;
   logic [7:0] pend_data_reg;
   logic [1:0] pend_ch_reg;
   logic src_wr_reg;
   logic [1:0] src_ch_reg;
   logic [7:0] src_data_reg;
   logic [NCH-1:0] cz_reg;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] mask_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;

   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pwrite & pready_reg;
   wire hit_mode = paddr == dma_arb_pkg::OFS_MODE;
   wire hit_src = paddr >= dma_arb_pkg::OFS_SRC0 && paddr <= dma_arb_pkg::OFS_SRC3
      && paddr[1:0] == 2'h0;
   wire [1:0] src_idx = 2'(paddr[7:2] - 6'h01);
   wire hit_status = paddr == dma_arb_pkg::OFS_STATUS;
   wire hit_mask = paddr == dma_arb_pkg::OFS_MASK;
   wire hit_req = paddr == dma_arb_pkg::OFS_REQ;
   wire mapped = hit_mode | hit_src | hit_status | hit_mask | hit_req;
   // Request bit is always written as one, a software trigger carries it too
   wire [7:0] src_fwd = pwdata[7:0] | dma_arb_pkg::SRC_REQ_MASK;
   wire src_changed = pwdata[3:0] != shadow_reg[src_idx][3:0];
   wire src_wr_now = wr_en & hit_src;
   wire [7:0] status_evt = {link.discard, link.start};

   wire [31:0] rd_src = {24'h000000, link.req[src_idx], shadow_reg[src_idx][6:0]};
   wire [31:0] rd_mux = hit_mode ? {24'h000000, mode_sw_reg} :
      hit_src ? rd_src :
      hit_status ? {24'h000000, status_reg} :
      hit_mask ? {24'h000000, mask_reg} :
      hit_req ? {28'h0000000, link.req} : 32'h00000000;

   // Set wins over a write-one clear in the same cycle
   assign status_next = (status_reg & ~((wr_en & hit_status) ? pwdata[7:0] : 8'h00)) | status_evt;

   // Channel held disabled while its source changes and for the guard time after
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_guard
         wire change_here = src_wr_now & src_changed & (src_idx == 2'(ch));
         assign mode_out_next[2*ch +: 2] = (guard_reg[ch] != 5'h00 || change_here) ?
            dma_arb_pkg::MODE_OFF : mode_sw_reg[2*ch +: 2];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               guard_reg[ch] <= 5'h00;
               shadow_reg[ch] <= dma_arb_pkg::SRC_RESET;
            end else begin
               if (change_here) begin
                  guard_reg[ch] <= dma_arb_pkg::GUARD_LOAD;
               end else if (guard_reg[ch] != 5'h00) begin
                  guard_reg[ch] <= guard_reg[ch] - 5'h01;
               end
               if (src_wr_now && src_idx == 2'(ch)) begin
                  shadow_reg[ch] <= pwdata[7:0] & dma_arb_pkg::SRC_KEEP_MASK;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 1'b0;
         pend_data_reg <= 8'h00;
         pend_ch_reg <= 2'h0;
         src_wr_reg <= 1'b0;
         src_ch_reg <= 2'h0;
         src_data_reg <= 8'h00;
      end else begin
         // A source change waits one cycle so the disable reaches the arbiter first
         pend_reg <= src_wr_now & src_changed;
         if (src_wr_now) begin
            pend_data_reg <= src_fwd;
            pend_ch_reg <= src_idx;
         end
         src_wr_reg <= pend_reg | (src_wr_now & ~src_changed);
         src_ch_reg <= pend_reg ? pend_ch_reg : src_idx;
         src_data_reg <= pend_reg ? pend_data_reg : src_fwd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sw_reg <= dma_arb_pkg::MODE_REG_RESET;
         mode_out_reg <= dma_arb_pkg::MODE_REG_RESET;
         cz_reg <= '0;
         status_reg <= dma_arb_pkg::STATUS_RESET;
         mask_reg <= dma_arb_pkg::MASK_RESET;
         irq_reg <= 1'b0;
      end else begin
         if (wr_en && hit_mode) begin
            mode_sw_reg <= pwdata[7:0];
         end
         if (wr_en && hit_mask) begin
            mask_reg <= pwdata[7:0];
         end
         mode_out_reg <= mode_out_next;
         cz_reg <= count_zero;
         status_reg <= status_next;
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   assign link.mode = mode_out_reg;
   assign link.src_wr = src_wr_reg;
   assign link.src_ch = src_ch_reg;
   assign link.src_data = src_data_reg;
   assign link.count_zero = cz_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

endmodule : dma_sw_port

/* rtl/dma_arb_pkg.sv */
// Shared constants and types for the DMA request arbiter and its software port
package dma_arb_pkg;

   localparam int NUM_CH = 4;
   localparam int CH_W = 2;

   // Transfer-mode field, two bits per channel
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h3;
   localparam logic [1:0] MODE_RESET = MODE_OFF;

   // Request source select layout
   localparam int SRC_REQ_BIT = 7;
   localparam int SRC_SW_BIT = 5;
   localparam int SRC_FIELD_LSB = 0;
   localparam int SRC_FIELD_W = 4;
   localparam logic [3:0] SRC_EXT_FALL = 4'hE;
   localparam logic [3:0] SRC_EXT_BOTH = 4'hF;
   localparam int MAX_PERIPH = 14;
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] SRC_REQ_MASK = 8'h80;
   localparam logic [7:0] SRC_KEEP_MASK = 8'h5F;

   // Least gap from a source change to re-enable, in pclk cycles
   localparam int GUARD_MIN_CYC = 26;
   localparam logic [4:0] GUARD_LOAD = 5'(GUARD_MIN_CYC + 1);

   // APB register map, byte addresses
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_SRC0 = 8'h04;
   localparam logic [7:0] OFS_SRC3 = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_MASK = 8'h18;
   localparam logic [7:0] OFS_REQ = 8'h1C;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] MODE_REG_RESET = 8'h00;

   typedef enum logic [1:0] {
      ARB_IDLE,
      ARB_XFER,
      ARB_WAIT_CPU
   } arb_state_t;

endpackage : dma_arb_pkg

/* rtl/dma_req_if.sv */
// Link between the software port and the DMA request arbiter
`timescale 1ns/1ps
interface dma_req_if;
   logic [2*dma_arb_pkg::NUM_CH-1:0] mode;
   logic src_wr;
   logic [dma_arb_pkg::CH_W-1:0] src_ch;
   logic [7:0] src_data;
   logic [dma_arb_pkg::NUM_CH-1:0] count_zero;
   logic [dma_arb_pkg::NUM_CH-1:0] req;
   logic [dma_arb_pkg::NUM_CH-1:0] start;
   logic [dma_arb_pkg::NUM_CH-1:0] discard;

   modport dev (
      input mode,
      input src_wr,
      input src_ch,
      input src_data,
      input count_zero,
      output req,
      output start,
      output discard
   );

   modport sw (
      output mode,
      output src_wr,
      output src_ch,
      output src_data,
      output count_zero,
      input req,
      input start,
      input discard
   );
endinterface : dma_req_if

/* rtl/dma_request_arbiter.sv */
// Request acceptance and fixed-priority cycle-steal arbitration for four DMA channels
`timescale 1ns/1ps
module dma_request_arbiter #(
   parameter int NUM_PERIPH = 8
) (
   input wire logic pclk, // 200 MHz clock
   input wire logic presetn, // Asynchronous reset, active low
   dma_req_if.dev link, // Configuration from the software port
   input wire logic [NUM_PERIPH-1:0] periph_irq, // Peripheral interrupt request set pulses
   input wire logic [dma_arb_pkg::NUM_CH-1:0] external_request_pin, // One pin per channel
   input wire logic unit_done, // Current transfer unit finished
   input wire logic cpu_access_done, // CPU finished one bus access
   output logic bus_grant, // DMA owns the system bus
   output logic [dma_arb_pkg::CH_W-1:0] grant_ch // Channel that owns the bus
);
   localparam int NCH = dma_arb_pkg::NUM_CH;

   generate
      if (NUM_PERIPH < 1 || NUM_PERIPH > dma_arb_pkg::MAX_PERIPH) begin : g_bad_periph
         $error("NUM_PERIPH out of range");
      end
   endgenerate

   dma_arb_pkg::arb_state_t state_reg;
   dma_arb_pkg::arb_state_t state_next;

   logic [NCH-1:0] req_reg;
   logic [NCH-1:0] req_next;
   logic [NCH-1:0] pin_prev_reg;
   logic [7:0] src_reg [NCH];
   logic [NCH-1:0] start_reg;
   logic [NCH-1:0] discard_reg;
   logic [NCH-1:0] discard_next;
   logic bus_grant_reg;
   logic [dma_arb_pkg::CH_W-1:0] grant_ch_reg;
   logic [dma_arb_pkg::CH_W-1:0] win_idx;

   logic [NCH-1:0] evt;
   logic [NCH-1:0] active;
   logic [NCH-1:0] accept;
   logic [NCH-1:0] first;
   logic [NCH-1:0] start_now;

   // Peripheral lines widened so the two external codes index a zero
   wire [15:0] irq_wide = 16'(periph_irq);

   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
         wire [1:0] md = link.mode[2*ch +: 2];
         wire [3:0] fld = src_reg[ch][dma_arb_pkg::SRC_FIELD_LSB +: dma_arb_pkg::SRC_FIELD_W];
         wire pin_fall = pin_prev_reg[ch] & ~external_request_pin[ch];
         wire pin_edge = pin_prev_reg[ch] ^ external_request_pin[ch];
         wire src_hit = link.src_wr && link.src_ch == 2'(ch);
         wire sw_trig = src_hit && link.src_data[dma_arb_pkg::SRC_SW_BIT]
            && link.src_data[dma_arb_pkg::SRC_REQ_BIT];
         wire periph_evt = irq_wide[fld];
         wire fall_evt = fld == dma_arb_pkg::SRC_EXT_FALL && pin_fall;
         wire both_evt = fld == dma_arb_pkg::SRC_EXT_BOTH && pin_edge;

         // All sources of one cycle are gathered in one term
         assign evt[ch] = periph_evt | fall_evt | both_evt | sw_trig;

         // Single needs a nonzero count, repeat runs on any request
         assign active[ch] = md == dma_arb_pkg::MODE_REPEAT
            || (md == dma_arb_pkg::MODE_SINGLE && !link.count_zero[ch]);

         // Mode resets to disabled, so nothing is accepted until enabled
         assign accept[ch] = req_reg[ch] & active[ch];

         // Disabled channel drops the request instead of transferring
         assign discard_next[ch] = ~active[ch] & (req_reg[ch] | evt[ch]);

         always_comb begin
            if (!active[ch]) begin
               req_next[ch] = 1'b0;
            end else if (evt[ch]) begin
               // A new request in the start cycle survives as the next request
               req_next[ch] = 1'b1;
            end else if (start_now[ch]) begin
               req_next[ch] = 1'b0;
            end else begin
               req_next[ch] = req_reg[ch];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               src_reg[ch] <= dma_arb_pkg::SRC_RESET;
            end else if (src_hit) begin
               // Whole byte stored, only the source field is read; the request bit is kept by req_reg
               src_reg[ch] <= link.src_data;
            end
         end
      end
   endgenerate

   // Lowest set bit wins
   assign first = accept & ~(accept - NCH'(1));

   always_comb begin
      win_idx = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (first[i]) begin
            win_idx = dma_arb_pkg::CH_W'(i);
         end
      end
   end

   assign start_now = (state_reg == dma_arb_pkg::ARB_IDLE) ? first : '0;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dma_arb_pkg::ARB_IDLE: begin
            if (|accept) begin
               state_next = dma_arb_pkg::ARB_XFER;
            end
         end
         dma_arb_pkg::ARB_XFER: begin
            // One unit only, then the CPU gets the bus back
            if (unit_done) begin
               state_next = dma_arb_pkg::ARB_WAIT_CPU;
            end
         end
         dma_arb_pkg::ARB_WAIT_CPU: begin
            // Stealing again before the CPU moves would starve it
            if (cpu_access_done) begin
               state_next = dma_arb_pkg::ARB_IDLE;
            end
         end
         default: begin
            state_next = dma_arb_pkg::ARB_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= dma_arb_pkg::ARB_IDLE;
         bus_grant_reg <= 1'b0;
         grant_ch_reg <= '0;
      end else begin
         state_reg <= state_next;
         bus_grant_reg <= state_next == dma_arb_pkg::ARB_XFER;
         if (|start_now) begin
            grant_ch_reg <= win_idx;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg <= '0;
         pin_prev_reg <= '1;
         start_reg <= '0;
         discard_reg <= '0;
      end else begin
         req_reg <= req_next;
         pin_prev_reg <= external_request_pin;
         start_reg <= start_now;
         discard_reg <= discard_next;
      end
   end

   assign link.req = req_reg;
   assign link.start = start_reg;
   assign link.discard = discard_reg;
   assign bus_grant = bus_grant_reg;
   assign grant_ch = grant_ch_reg;

endmodule : dma_request_arbiter

/* sim/dma_arb_props.sv */
// Concurrent checks on the link between the software port and the arbiter
`timescale 1ns/1ps
module dma_arb_props (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic [2*dma_arb_pkg::NUM_CH-1:0] mode, // Channel modes
   input wire logic src_wr, // Source write pulse
   input wire logic [dma_arb_pkg::CH_W-1:0] src_ch, // Written channel
   input wire logic [7:0] src_data, // Written source value
   input wire logic [dma_arb_pkg::NUM_CH-1:0] count_zero, // Count is zero
   input wire logic [dma_arb_pkg::NUM_CH-1:0] req, // Request bits
   input wire logic [dma_arb_pkg::NUM_CH-1:0] start, // Transfer starts
   input wire logic [dma_arb_pkg::NUM_CH-1:0] discard // Dropped requests
);
   logic [dma_arb_pkg::NUM_CH-1:0] act;
   logic [dma_arb_pkg::NUM_CH-1:0] pend;

   // Mode 10 counts as off, like 00
   always_comb begin
      for (int i = 0; i < dma_arb_pkg::NUM_CH; i++) begin
         act[i] = (mode[2*i+:2] == dma_arb_pkg::MODE_REPEAT)
            || ((mode[2*i+:2] == dma_arb_pkg::MODE_SINGLE) && !count_zero[i]);
      end
   end
   assign pend = req & act;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   start_from_req_a: assert property ((start & ~$past(req)) == 4'h0)
      else $error("start without a request bit");
   start_active_a: assert property ((start & ~$past(act)) == 4'h0)
      else $error("start on an inactive channel");
   fixed_priority_a: assert property ((start != 4'h0) |->
      (start == ($past(pend) & (~$past(pend) + 4'h1))))
      else $error("start is not the lowest pending channel");
   one_unit_a: assert property ($onehot0(start))
      else $error("more than one channel started");
   discard_off_a: assert property ((discard & $past(act)) == 4'h0)
      else $error("request dropped on an active channel");
   start_or_drop_a: assert property ((start & discard) == 4'h0)
      else $error("request both started and dropped");
   req_hold_a: assert property (($past(req) & ~req & ~(start | discard)) == 4'h0)
      else $error("request bit cleared without start or drop");
   // An inactive channel drops a trigger, so only active channels must latch it
   sw_trigger_a: assert property ((src_wr && src_data[7] && src_data[5] && act[src_ch])
      |=> req[$past(src_ch)])
      else $error("software trigger did not set the request bit");
   mode_reset_a: assert property ($rose(presetn) |-> (mode == 8'h00))
      else $error("mode not disabled after reset");

   cover property (start[0]);
   cover property ((start != 4'h0) && ($countones($past(req)) > 1));
   cover property (discard != 4'h0);
   cover property (src_wr && src_data[5]);
endmodule : dma_arb_props

/* sim/tb_top.sv */
// Self-checking bench for the DMA software port and arbiter pair
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] SRC1 = dma_arb_pkg::OFS_SRC0 + 8'h04;
   localparam logic [7:0] SRC2 = dma_arb_pkg::OFS_SRC0 + 8'h08;
   localparam logic [7:0] SRC3 = dma_arb_pkg::OFS_SRC0 + 8'h0C;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [3:0] count_zero = 4'h0;
   logic [7:0] periph_irq = 8'h00;
   logic [3:0] ext_pin = 4'hF;
   logic unit_done = 1'h0;
   logic cpu_access_done = 1'h0;
   logic bus_grant;
   logic [1:0] grant_ch;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int samples_checked = 0;

   dma_req_if link_if ();
   dma_sw_port u_dma_sw_port (.pclk(pclk), .presetn(presetn), .link(link_if.sw),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_zero(count_zero), .irq(irq));
   dma_request_arbiter #(.NUM_PERIPH(8)) u_dma_request_arbiter (.pclk(pclk),
      .presetn(presetn), .link(link_if.dev), .periph_irq(periph_irq),
      .external_request_pin(ext_pin), .unit_done(unit_done),
      .cpu_access_done(cpu_access_done), .bus_grant(bus_grant), .grant_ch(grant_ch));
   dma_arb_props u_dma_arb_props (.pclk(pclk), .presetn(presetn), .mode(link_if.mode),
      .src_wr(link_if.src_wr), .src_ch(link_if.src_ch), .src_data(link_if.src_data),
      .count_zero(link_if.count_zero), .req(link_if.req), .start(link_if.start),
      .discard(link_if.discard));

   always #2.5 pclk = ~pclk;

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Reads of pready at the edge see the value sampled there, before the flop updates
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check(name, exp, rd);
   endtask : rdchk

   task automatic pulse(input logic [7:0] m);
      @(posedge pclk);
      periph_irq <= m;
      @(posedge pclk);
      periph_irq <= 8'h00;
   endtask : pulse

   // Holds the bus release for four cycles so a waiting channel cannot sneak in early
   task automatic serve(input logic [1:0] ch, input logic [3:0] exp_req);
      do @(posedge pclk); while (bus_grant !== 1'h1);
      check("grant_ch", {30'h0, ch}, {30'h0, grant_ch});
      unit_done <= 1'h1;
      @(posedge pclk);
      unit_done <= 1'h0;
      repeat (4) begin
         @(posedge pclk);
         check("bus_grant", 32'h0, {31'h0, bus_grant});
      end
      check("req", {28'h0, exp_req}, {28'h0, link_if.req});
      cpu_access_done <= 1'h1;
      @(posedge pclk);
      cpu_access_done <= 1'h0;
   endtask : serve

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      #50us;
      num_errors++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      rdchk("mode", dma_arb_pkg::OFS_MODE, 32'h0);
      rdchk("src0", dma_arb_pkg::OFS_SRC0, 32'h0);
      rdchk("req", dma_arb_pkg::OFS_REQ, 32'h0);
      rdchk("status", dma_arb_pkg::OFS_STATUS, 32'h0);
      rdchk("mask", dma_arb_pkg::OFS_MASK, 32'h0);
      apb(1'h0, 8'h20, 32'h0);
      check("unmapped", 32'h1, {31'h0, err});
      $display("test reset done");
      wr(dma_arb_pkg::OFS_MASK, 32'hFF);
      wr(dma_arb_pkg::OFS_SRC0, 32'h82);
      wr(SRC1, 32'h83);
      repeat (30) @(posedge pclk);
      wr(dma_arb_pkg::OFS_MODE, 32'h0F);
      pulse(8'h0C);
      @(posedge pclk);
      check("req", 32'h3, {28'h0, link_if.req});
      serve(2'h0, 4'h2);
      serve(2'h1, 4'h0);
      rdchk("status", dma_arb_pkg::OFS_STATUS, 32'h03);
      check("irq", 32'h1, {31'h0, irq});
      wr(dma_arb_pkg::OFS_STATUS, 32'h03);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0, {31'h0, irq});
      $display("test priority done");
      wr(SRC2, 32'h84);
      repeat (30) @(posedge pclk);
      pulse(8'h10);
      repeat (3) @(posedge pclk);
      rdchk("status", dma_arb_pkg::OFS_STATUS, 32'h40);
      rdchk("req", dma_arb_pkg::OFS_REQ, 32'h0);
      wr(dma_arb_pkg::OFS_MASK, 32'h0F);
      repeat (2) @(posedge pclk);
      check("irq", 32'h0, {31'h0, irq});
      wr(dma_arb_pkg::OFS_MASK, 32'hFF);
      repeat (2) @(posedge pclk);
      check("irq", 32'h1, {31'h0, irq});
      wr(dma_arb_pkg::OFS_STATUS, 32'h40);
      count_zero <= 4'h8;
      wr(SRC3, 32'h85);
      repeat (30) @(posedge pclk);
      wr(dma_arb_pkg::OFS_MODE, 32'h4F);
      pulse(8'h20);
      repeat (3) @(posedge pclk);
      rdchk("status", dma_arb_pkg::OFS_STATUS, 32'h80);
      wr(dma_arb_pkg::OFS_STATUS, 32'h80);
      count_zero <= 4'h0;
      repeat (3) @(posedge pclk);
      pulse(8'h20);
      serve(2'h3, 4'h0);
      $display("test discard done");
      // Channel 1 is disabled around each source change
      wr(dma_arb_pkg::OFS_MODE, 32'h43);
      wr(SRC1, 32'h8E);
      repeat (30) @(posedge pclk);
      wr(dma_arb_pkg::OFS_MODE, 32'h4F);
      repeat (2) @(posedge pclk);
      ext_pin[1] <= 1'h0;
      serve(2'h1, 4'h0);
      ext_pin[1] <= 1'h1;
      repeat (10) @(posedge pclk);
      rdchk("req", dma_arb_pkg::OFS_REQ, 32'h0);
      check("bus_grant", 32'h0, {31'h0, bus_grant});
      wr(dma_arb_pkg::OFS_MODE, 32'h43);
      wr(SRC1, 32'h8F);
      repeat (30) @(posedge pclk);
      wr(dma_arb_pkg::OFS_MODE, 32'h4F);
      repeat (2) @(posedge pclk);
      ext_pin[1] <= 1'h0;
      serve(2'h1, 4'h0);
      ext_pin[1] <= 1'h1;
      serve(2'h1, 4'h0);
      $display("test external done");
      wr(dma_arb_pkg::OFS_SRC0, 32'hA2);
      serve(2'h0, 4'h0);
      rdchk("src0", dma_arb_pkg::OFS_SRC0, 32'h02);
      // Sources are already quiet, so the channels go off last
      wr(dma_arb_pkg::OFS_MODE, 32'h00);
      rdchk("mode", dma_arb_pkg::OFS_MODE, 32'h0);
      $display("test trigger done");
      final_report();
   end
endmodule : tb_top
